//--- rtl/dbgak_device.sv
// device end of the debug pin acknowledge handshake
// assumes commands arrive fully framed as one-cycle strobes on the link,
// and that bus and cpu completion inputs are on the same clock
//
// Operation
// - ack-on enables pulses after cpu commands
// - ack-on itself answered by a pulse
// - ack-off stops later pulses except the one answering a later ack-on
// - host waits worst-case delay when disabled
// - reset leaves acknowledge disabled
// - read ack after bus cycle done
// - write ack after data and bus write
// - host probes support with ack-on
// - unsupported target ignores ack-on silently
// - enter-debug ack when cpu halts
// - resume ack when cpu leaves debug
// - resume-until-halt ack on next halt entry
// - host prefers resume-until-halt for breakpoints
// - single step one instruction, ack on re-entry
// - resync cancels pending cpu-command ack
// - tagged resume never acknowledged
// - debug pin driven pseudo-open-drain
`timescale 1ns/1ps
`default_nettype none
module dbgak_device #(
  parameter int ACK_LOW  = dbgak_pkg::ACK_LOW_CYCLES,
  parameter int ACK_HIGH = dbgak_pkg::ACK_HIGH_CYCLES,
  parameter bit HANDSHAKE_SUPPORT = 1'b1
) (
  input  wire logic      clk,
  input  wire logic      srst,
  dbgak_link_if.device   link,
  output logic           busReq,
  output logic           busWrite,
  input  wire logic      busDone,
  output logic           haltReq,
  output logic           resumeReq,
  output logic           stepReq,
  input  wire logic      cpuEnteredBgnd,
  input  wire logic      cpuLeftBgnd,
  output logic           ackEnabled,
  output logic           busy
);

  localparam int CW = dbgak_pkg::CNT_WIDTH;

  if (ACK_LOW < 1 || ACK_HIGH < 1 || ACK_LOW >= (1 << CW) || ACK_HIGH >= (1 << CW)) begin : g_chk
    $error("dbgak_device: pulse counts out of range");
  end

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_BUS    = 6'b000010,
    ST_WENTER = 6'b000100,
    ST_WEXIT  = 6'b001000,
    ST_LOW    = 6'b010000,
    ST_HIGH   = 6'b100000
  } dbgak_dev_state_t;

  dbgak_dev_state_t  state_r;
  dbgak_dev_state_t  state_nxt;
  logic              ackEn_r;
  logic              ackEn_nxt;
  logic              cancelable_r;
  logic              cancelable_nxt;
  logic [CW-1:0]     cnt_r;
  logic [CW-1:0]     cnt_nxt;
  logic              busReq_r;
  logic              busReq_nxt;
  logic              busWrite_r;
  logic              busWrite_nxt;
  logic              haltReq_r;
  logic              haltReq_nxt;
  logic              resumeReq_r;
  logic              resumeReq_nxt;
  logic              stepReq_r;
  logic              stepReq_nxt;
  logic              pinOut_r;
  logic              pinOut_nxt;
  logic              pinOe_r;
  logic              pinOe_nxt;

  // start a pulse if enabled, else go idle
  function automatic dbgak_dev_state_t finish(input logic en);
    finish = en ? ST_LOW : ST_IDLE;
  endfunction

  always_comb begin
    state_nxt      = state_r;
    ackEn_nxt      = ackEn_r;
    cancelable_nxt = cancelable_r;
    cnt_nxt        = cnt_r;
    busReq_nxt     = 1'b0;
    busWrite_nxt   = busWrite_r;
    haltReq_nxt    = 1'b0;
    resumeReq_nxt  = 1'b0;
    stepReq_nxt    = 1'b0;
    pinOut_nxt     = 1'b1;
    pinOe_nxt      = 1'b0;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt        = CW'(ACK_LOW - 1);
        cancelable_nxt = 1'b0;
        if (link.cmdValid) begin
          case (link.cmdCode)
            dbgak_pkg::CMD_ACK_ON: begin
              if (HANDSHAKE_SUPPORT) begin
                ackEn_nxt = 1'b1;
                state_nxt = ST_LOW;
              end
            end
            dbgak_pkg::CMD_ACK_OFF: begin
              ackEn_nxt = 1'b0;
            end
            dbgak_pkg::CMD_READ: begin
              busReq_nxt   = 1'b1;
              busWrite_nxt = 1'b0;
              state_nxt    = ST_BUS;
            end
            dbgak_pkg::CMD_WRITE: begin
              busReq_nxt   = 1'b1;
              busWrite_nxt = 1'b1;
              state_nxt    = ST_BUS;
            end
            dbgak_pkg::CMD_ENTER_DEBUG: begin
              haltReq_nxt    = 1'b1;
              cancelable_nxt = 1'b1;
              state_nxt      = ST_WENTER;
            end
            dbgak_pkg::CMD_RESUME: begin
              resumeReq_nxt  = 1'b1;
              cancelable_nxt = 1'b1;
              state_nxt      = ST_WEXIT;
            end
            dbgak_pkg::CMD_RESUME_UNTIL_HALT: begin
              resumeReq_nxt  = 1'b1;
              cancelable_nxt = 1'b1;
              state_nxt      = ST_WENTER;
            end
            dbgak_pkg::CMD_SINGLE_STEP: begin
              stepReq_nxt    = 1'b1;
              cancelable_nxt = 1'b1;
              state_nxt      = ST_WENTER;
            end
            dbgak_pkg::CMD_TAGGED_RESUME: begin
              resumeReq_nxt = 1'b1;
            end
            default: begin
              state_nxt = ST_IDLE;
            end
          endcase
        end
      end
      ST_BUS: begin
        if (busDone) begin
          state_nxt = finish(ackEn_r);
        end
      end
      ST_WENTER: begin
        if (cancelable_r && link.cmdValid && link.cmdCode == dbgak_pkg::CMD_RESYNC) begin
          state_nxt = ST_IDLE;
        end else if (cpuEnteredBgnd) begin
          state_nxt = finish(ackEn_r);
        end
      end
      ST_WEXIT: begin
        if (cancelable_r && link.cmdValid && link.cmdCode == dbgak_pkg::CMD_RESYNC) begin
          state_nxt = ST_IDLE;
        end else if (cpuLeftBgnd) begin
          state_nxt = finish(ackEn_r);
        end
      end
      ST_LOW: begin
        pinOut_nxt = 1'b0;
        pinOe_nxt  = 1'b1;
        if (cnt_r == '0) begin
          cnt_nxt    = CW'(ACK_HIGH - 1);
          state_nxt  = ST_HIGH;
        end else begin
          cnt_nxt = cnt_r - CW'(1);
        end
      end
      ST_HIGH: begin
        pinOut_nxt = 1'b1;
        pinOe_nxt  = 1'b1;
        if (cnt_r == '0) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - CW'(1);
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r      <= ST_IDLE;
      ackEn_r      <= dbgak_pkg::ACK_EN_RESET;
      cancelable_r <= 1'b0;
      cnt_r        <= '0;
      busReq_r     <= 1'b0;
      busWrite_r   <= 1'b0;
      haltReq_r    <= 1'b0;
      resumeReq_r  <= 1'b0;
      stepReq_r    <= 1'b0;
      pinOut_r     <= 1'b1;
      pinOe_r      <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      ackEn_r      <= ackEn_nxt;
      cancelable_r <= cancelable_nxt;
      cnt_r        <= cnt_nxt;
      busReq_r     <= busReq_nxt;
      busWrite_r   <= busWrite_nxt;
      haltReq_r    <= haltReq_nxt;
      resumeReq_r  <= resumeReq_nxt;
      stepReq_r    <= stepReq_nxt;
      pinOut_r     <= pinOut_nxt;
      pinOe_r      <= pinOe_nxt;
    end
  end

  assign link.devPinOut = pinOut_r;
  assign link.devPinOe  = pinOe_r;
  assign busReq         = busReq_r;
  assign busWrite       = busWrite_r;
  assign haltReq        = haltReq_r;
  assign resumeReq      = resumeReq_r;
  assign stepReq        = stepReq_r;
  assign ackEnabled     = ackEn_r;
  assign busy           = (state_r != ST_IDLE) || pinOe_r;

endmodule
`default_nettype wire

//--- rtl/dbgak_pkg.sv
// shared constants of the debug pin acknowledge handshake
// assumes a single 100 MHz clock on both ends
package dbgak_pkg;

  // command codes carried from host end to device end
  localparam logic [3:0] CMD_NONE              = 4'h0;
  localparam logic [3:0] CMD_ACK_ON            = 4'h1;
  localparam logic [3:0] CMD_ACK_OFF           = 4'h2;
  localparam logic [3:0] CMD_READ              = 4'h3;
  localparam logic [3:0] CMD_WRITE             = 4'h4;
  localparam logic [3:0] CMD_ENTER_DEBUG       = 4'h5;
  localparam logic [3:0] CMD_RESUME            = 4'h6;
  localparam logic [3:0] CMD_RESUME_UNTIL_HALT = 4'h7;
  localparam logic [3:0] CMD_SINGLE_STEP       = 4'h8;
  localparam logic [3:0] CMD_TAGGED_RESUME     = 4'h9;
  localparam logic [3:0] CMD_RESYNC            = 4'hA;
  localparam int         CMD_WIDTH             = 4;

  // timing
  localparam int CLK_PERIOD_NS       = 10;
  localparam int ACK_LOW_CYCLES      = 16;
  localparam int ACK_HIGH_CYCLES     = 1;
  localparam int WORST_WAIT_NS       = 2000;
  localparam int WORST_WAIT_CYCLES   = WORST_WAIT_NS / CLK_PERIOD_NS;
  localparam int ACK_TIMEOUT_NS      = 2000;
  localparam int ACK_TIMEOUT_CYCLES  = ACK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int CNT_WIDTH           = 12;

  // reset values
  localparam logic ACK_EN_RESET = 1'b0;

endpackage

//--- rtl/dbgak_link_if.sv
// link between host end and device end: command strobe and debug pin
// assumes a pull-up on the debug pin; either end may drive it
`timescale 1ns/1ps
`default_nettype none
interface dbgak_link_if;
  logic                         cmdValid;
  logic [dbgak_pkg::CMD_WIDTH-1:0] cmdCode;
  logic                         devPinOut;
  logic                         devPinOe;
  logic                         hostPinOut;
  logic                         hostPinOe;
  logic                         pinLevel;

  // wired level with pull-up
  assign pinLevel = (devPinOe ? devPinOut : 1'b1) & (hostPinOe ? hostPinOut : 1'b1);

  modport device (
    input  cmdValid,
    input  cmdCode,
    output devPinOut,
    output devPinOe,
    input  pinLevel
  );

  modport host (
    output cmdValid,
    output cmdCode,
    output hostPinOut,
    output hostPinOe,
    input  pinLevel
  );
endinterface
`default_nettype wire

//--- rtl/dbgak_host.sv
// host end of the debug pin acknowledge handshake
// assumes framing is done elsewhere; commands go out as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module dbgak_host #(
  parameter int WORST_WAIT  = dbgak_pkg::WORST_WAIT_CYCLES,
  parameter int ACK_TIMEOUT = dbgak_pkg::ACK_TIMEOUT_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          srst,
  dbgak_link_if.host                         link,
  input  wire logic                          reqValid,
  input  wire logic [dbgak_pkg::CMD_WIDTH-1:0] reqCmd,
  output logic                               reqReady,
  input  wire logic                          abortReq,
  output logic                               doneValid,
  output logic                               doneAcked,
  output logic                               ackEnabled,
  output logic                               targetSupports
);

  localparam int CW = dbgak_pkg::CNT_WIDTH;

  if (WORST_WAIT < 1 || ACK_TIMEOUT < 1 || WORST_WAIT >= (1 << CW)
      || ACK_TIMEOUT >= (1 << CW)) begin : g_chk
    $error("dbgak_host: wait counts out of range");
  end

  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_WAIT = 2'b10
  } dbgak_host_state_t;

  dbgak_host_state_t          state_r;
  dbgak_host_state_t          state_nxt;
  logic                       expect_r;
  logic                       expect_nxt;
  logic [dbgak_pkg::CMD_WIDTH-1:0] cmd_r;
  logic [dbgak_pkg::CMD_WIDTH-1:0] cmd_nxt;
  logic                       cmdValid_r;
  logic                       cmdValid_nxt;
  logic [CW-1:0]              cnt_r;
  logic [CW-1:0]              cnt_nxt;
  logic                       ackEn_r;
  logic                       ackEn_nxt;
  logic                       supports_r;
  logic                       supports_nxt;
  logic                       done_r;
  logic                       done_nxt;
  logic                       acked_r;
  logic                       acked_nxt;
  logic                       pinMeta_r;
  logic                       pinSync_r;
  logic                       pinPrev_r;
  logic                       ackSeen;

  assign ackSeen  = pinPrev_r & ~pinSync_r;
  assign reqReady = (state_r == HS_IDLE);

  always_comb begin
    state_nxt    = state_r;
    expect_nxt   = expect_r;
    cmd_nxt      = cmd_r;
    cmdValid_nxt = 1'b0;
    cnt_nxt      = cnt_r;
    ackEn_nxt    = ackEn_r;
    supports_nxt = supports_r;
    done_nxt     = 1'b0;
    acked_nxt    = acked_r;
    case (state_r)
      HS_IDLE: begin
        if (reqValid) begin
          cmd_nxt      = reqCmd;
          cmdValid_nxt = 1'b1;
          state_nxt    = HS_WAIT;
          expect_nxt   = (reqCmd == dbgak_pkg::CMD_ACK_ON) ||
                         (ackEn_r && reqCmd != dbgak_pkg::CMD_ACK_OFF &&
                          reqCmd != dbgak_pkg::CMD_TAGGED_RESUME &&
                          reqCmd != dbgak_pkg::CMD_RESYNC);
          cnt_nxt      = expect_nxt ? CW'(ACK_TIMEOUT - 1) : CW'(WORST_WAIT - 1);
          if (reqCmd == dbgak_pkg::CMD_ACK_OFF) begin
            ackEn_nxt = 1'b0;
          end
        end
      end
      HS_WAIT: begin
        if (abortReq) begin
          cmd_nxt      = dbgak_pkg::CMD_RESYNC;
          cmdValid_nxt = 1'b1;
          done_nxt     = 1'b1;
          acked_nxt    = 1'b0;
          state_nxt    = HS_IDLE;
        end else if (expect_r && ackSeen) begin
          done_nxt  = 1'b1;
          acked_nxt = 1'b1;
          state_nxt = HS_IDLE;
          if (cmd_r == dbgak_pkg::CMD_ACK_ON) begin
            ackEn_nxt    = 1'b1;
            supports_nxt = 1'b1;
          end
        end else if (cnt_r == '0) begin
          done_nxt  = 1'b1;
          acked_nxt = 1'b0;
          state_nxt = HS_IDLE;
          if (cmd_r == dbgak_pkg::CMD_ACK_ON) begin
            ackEn_nxt    = 1'b0;
            supports_nxt = 1'b0;
          end
        end else begin
          cnt_nxt = cnt_r - CW'(1);
        end
      end
      default: begin
        state_nxt = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r    <= HS_IDLE;
      expect_r   <= 1'b0;
      cmd_r      <= dbgak_pkg::CMD_NONE;
      cmdValid_r <= 1'b0;
      cnt_r      <= '0;
      ackEn_r    <= dbgak_pkg::ACK_EN_RESET;
      supports_r <= 1'b0;
      done_r     <= 1'b0;
      acked_r    <= 1'b0;
      pinMeta_r  <= 1'b1;
      pinSync_r  <= 1'b1;
      pinPrev_r  <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      expect_r   <= expect_nxt;
      cmd_r      <= cmd_nxt;
      cmdValid_r <= cmdValid_nxt;
      cnt_r      <= cnt_nxt;
      ackEn_r    <= ackEn_nxt;
      supports_r <= supports_nxt;
      done_r     <= done_nxt;
      acked_r    <= acked_nxt;
      pinMeta_r  <= link.pinLevel;
      pinSync_r  <= pinMeta_r;
      pinPrev_r  <= pinSync_r;
    end
  end

  assign link.cmdValid   = cmdValid_r;
  assign link.cmdCode    = cmd_r;
  assign link.hostPinOut = 1'b1;
  assign link.hostPinOe  = 1'b0;
  assign doneValid       = done_r;
  assign doneAcked       = acked_r;
  assign ackEnabled      = ackEn_r;
  assign targetSupports  = supports_r;

endmodule
`default_nettype wire

//--- verification/dbgak_checker.sv
// assertions on the link between host end and device end
// assumes one clock, srst synchronous active high, host never drives the pin
`timescale 1ns/1ps
`default_nettype none
module dbgak_checker #(
  parameter int ACK_LOW = dbgak_pkg::ACK_LOW_CYCLES
) (
  input wire logic                           clk,
  input wire logic                           srst,
  input wire logic                           cmdValid,
  input wire logic [dbgak_pkg::CMD_WIDTH-1:0] cmdCode,
  input wire logic                           devPinOut,
  input wire logic                           devPinOe,
  input wire logic                           pinLevel
);
  logic [7:0] lowCnt_r;
  logic [7:0] lowCnt_nxt;
  logic       ackOn_r;
  logic       ackOn_nxt;

  // low-phase length and enable state seen from commands
  always_comb begin
    lowCnt_nxt = lowCnt_r;
    ackOn_nxt  = ackOn_r;
    if (!devPinOe) lowCnt_nxt = 8'h00;
    else if (!devPinOut) lowCnt_nxt = lowCnt_r + 8'h01;
    if (cmdValid && cmdCode == dbgak_pkg::CMD_ACK_ON) ackOn_nxt = 1'b1;
    if (cmdValid && cmdCode == dbgak_pkg::CMD_ACK_OFF) ackOn_nxt = 1'b0;
    if (srst) begin
      lowCnt_nxt = 8'h00;
      ackOn_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    lowCnt_r <= lowCnt_nxt;
    ackOn_r  <= ackOn_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_reset_pin_free: assert property (disable iff (1'b0) srst |=> !devPinOe)
    else $error("pin driven after reset");
  a_pulse_starts_low: assert property ($rose(devPinOe) |-> !devPinOut && !pinLevel)
    else $error("pulse does not start low");
  a_low_phase_len: assert property (devPinOe && devPinOut |-> lowCnt_r == 8'(ACK_LOW))
    else $error("low phase length wrong");
  a_high_one_cycle: assert property (devPinOe && devPinOut |=> !devPinOe)
    else $error("high drive not one cycle");
  a_high_before_free: assert property ($fell(devPinOe) |-> $past(devPinOut))
    else $error("pin released while low");
  a_ack_on_answer: assert property (
    cmdValid && cmdCode == dbgak_pkg::CMD_ACK_ON && !devPinOe
    |-> ##2 devPinOe && !devPinOut)
    else $error("handshake-on not answered");
  a_pulse_gated_en: assert property ($rose(devPinOe) |-> ackOn_r)
    else $error("pulse while disabled");
  a_tagged_silent: assert property (
    cmdValid && cmdCode == dbgak_pkg::CMD_TAGGED_RESUME && !devPinOe
    |=> (!devPinOe)[*8])
    else $error("pulse after tagged resume");
  a_resync_cancels: assert property (
    cmdValid && cmdCode == dbgak_pkg::CMD_RESYNC && !devPinOe
    |=> (!devPinOe)[*8])
    else $error("pulse after resync");

  c_ack_on: cover property (cmdValid && cmdCode == dbgak_pkg::CMD_ACK_ON);
  c_pulse: cover property ($rose(devPinOe));
  c_tagged: cover property (cmdValid && cmdCode == dbgak_pkg::CMD_TAGGED_RESUME);
  c_resync: cover property (cmdValid && cmdCode == dbgak_pkg::CMD_RESYNC);
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench: host end and device end joined by the link
// assumes bus and cpu replies are modelled here with random delays
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk;
  logic       srst;
  logic       reqValid;
  logic [3:0] reqCmd;
  logic       reqReady;
  logic       abortReq;
  logic       doneValid;
  logic       doneAcked;
  logic       hostAckEn;
  logic       targetSupports;
  logic       busReq;
  logic       busWrite;
  logic       busDone;
  logic       haltReq;
  logic       resumeReq;
  logic       stepReq;
  logic       cpuEnteredBgnd;
  logic       cpuLeftBgnd;
  logic       devAckEn;
  logic       busy;
  logic       stall;
  logic       reqValid2;
  logic       done2;
  logic       acked2;
  logic       sup2;
  logic [3:0] reqCmd2;
  logic       abortReq2;
  logic [3:0] lastCmd;
  logic [31:0] rnd;
  int         fails;
  int         samples_checked;
  logic       expQ[$];

  dbgak_link_if link();
  dbgak_link_if link2();

  dbgak_device #(.HANDSHAKE_SUPPORT(1'b1)) dbgak_device_inst (.clk(clk), .srst(srst),
    .link(link), .busReq(busReq), .busWrite(busWrite), .busDone(busDone),
    .haltReq(haltReq), .resumeReq(resumeReq), .stepReq(stepReq),
    .cpuEnteredBgnd(cpuEnteredBgnd), .cpuLeftBgnd(cpuLeftBgnd),
    .ackEnabled(devAckEn), .busy(busy));
  dbgak_host #(.WORST_WAIT(40), .ACK_TIMEOUT(40)) dbgak_host_inst (.clk(clk), .srst(srst),
    .link(link), .reqValid(reqValid), .reqCmd(reqCmd), .reqReady(reqReady),
    .abortReq(abortReq), .doneValid(doneValid), .doneAcked(doneAcked),
    .ackEnabled(hostAckEn), .targetSupports(targetSupports));
  dbgak_checker dbgak_checker_inst (.clk(clk), .srst(srst), .cmdValid(link.cmdValid),
    .cmdCode(link.cmdCode), .devPinOut(link.devPinOut), .devPinOe(link.devPinOe),
    .pinLevel(link.pinLevel));

  // target without handshake support
  dbgak_device #(.HANDSHAKE_SUPPORT(1'b0)) dbgak_device_nosup_inst (.clk(clk),
    .srst(srst), .link(link2), .busReq(), .busWrite(), .busDone(busDone), .haltReq(),
    .resumeReq(), .stepReq(), .cpuEnteredBgnd(cpuEnteredBgnd), .cpuLeftBgnd(cpuLeftBgnd),
    .ackEnabled(), .busy());
  dbgak_host #(.WORST_WAIT(40), .ACK_TIMEOUT(40)) dbgak_host_nosup_inst (.clk(clk),
    .srst(srst), .link(link2), .reqValid(reqValid2), .reqCmd(reqCmd2),
    .reqReady(), .abortReq(abortReq2), .doneValid(done2), .doneAcked(acked2),
    .ackEnabled(), .targetSupports(sup2));

  function automatic int dly();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return 1 + int'(rnd[2:0]);
  endfunction

  task automatic check(string nm, logic [1:0] exp, logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %0h got %0h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // cpu and bus replies
  task automatic ev(int which, int n);
    repeat (n) @(posedge clk);
    if (!stall) begin
      #1;
      if (which == 0) busDone = 1'b1;
      else if (which == 1) cpuEnteredBgnd = 1'b1;
      else cpuLeftBgnd = 1'b1;
      @(posedge clk);
      #1;
      busDone = 1'b0;
      cpuEnteredBgnd = 1'b0;
      cpuLeftBgnd = 1'b0;
    end
  endtask

  always @(posedge clk) begin
    int d;
    d = dly();
    if (busReq) begin
      check("bus write", {1'b0, lastCmd == dbgak_pkg::CMD_WRITE}, {1'b0, busWrite});
    end
    if (haltReq || stepReq) begin
      check("cpu req", {1'b0, lastCmd == dbgak_pkg::CMD_SINGLE_STEP}, {1'b0, stepReq});
    end
    if (busReq) fork ev(0, d); join_none
    if (haltReq) fork ev(1, d); join_none
    if (resumeReq || stepReq) fork ev(2, d); ev(1, d + 3); join_none
  end

  // done monitor
  always @(posedge clk) begin
    if (doneValid === 1'b1) begin
      if (expQ.size() == 0) check("spare done", 2'h0, 2'h1);
      else check("done acked", {1'b0, expQ.pop_front()}, {1'b0, doneAcked});
    end
  end

  task automatic send(logic [3:0] cmd, logic expAck, logic expEn, int abortAfter);
    int n;
    n = 0;
    while ((reqReady !== 1'b1 || busy !== 1'b0) && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("ready", 2'h1, {1'b0, reqReady === 1'b1 && busy === 1'b0});
    reqValid = 1'b1;
    reqCmd = cmd;
    lastCmd = cmd;
    expQ.push_back(expAck);
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    if (abortAfter > 0) begin
      repeat (abortAfter) @(posedge clk);
      #1;
      abortReq = 1'b1;
      @(posedge clk);
      #1;
      abortReq = 1'b0;
    end
    n = 0;
    while (doneValid !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("done seen", 2'h1, {1'b0, doneValid === 1'b1});
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("idle", 2'h0, {1'b0, busy !== 1'b0});
    check("enable", {expEn, expEn}, {devAckEn, hostAckEn});
  endtask

  task automatic do_reset();
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    fails++;
    test_done();
  end

  initial begin
    logic [3:0] cmds[6];
    logic       en;
    int         k;
    cmds = '{dbgak_pkg::CMD_READ, dbgak_pkg::CMD_WRITE, dbgak_pkg::CMD_ENTER_DEBUG,
             dbgak_pkg::CMD_RESUME, dbgak_pkg::CMD_RESUME_UNTIL_HALT,
             dbgak_pkg::CMD_SINGLE_STEP};
    rnd = 32'h82AB;
    {reqValid, abortReq, busDone, cpuEnteredBgnd, cpuLeftBgnd, stall, reqValid2} = '0;
    abortReq2 = 1'b0;
    reqCmd = dbgak_pkg::CMD_NONE;
    reqCmd2 = dbgak_pkg::CMD_ACK_ON;
    srst = 1'b1;
    do_reset();
    check("reset enable", 2'h0, {devAckEn, hostAckEn});
    send(dbgak_pkg::CMD_READ, 1'b0, 1'b0, 0);
    send(dbgak_pkg::CMD_ACK_ON, 1'b1, 1'b1, 0);
    check("supports", 2'h1, {1'b0, targetSupports});
    foreach (cmds[i]) send(cmds[i], 1'b1, 1'b1, 0);
    send(dbgak_pkg::CMD_TAGGED_RESUME, 1'b0, 1'b1, 0);
    stall = 1'b1;
    send(dbgak_pkg::CMD_ENTER_DEBUG, 1'b0, 1'b1, 3);
    repeat (12) @(posedge clk);
    #1;
    stall = 1'b0;
    send(dbgak_pkg::CMD_SINGLE_STEP, 1'b1, 1'b1, 0);
    send(dbgak_pkg::CMD_RESUME_UNTIL_HALT, 1'b1, 1'b1, 0);
    send(dbgak_pkg::CMD_ACK_OFF, 1'b0, 1'b0, 0);
    send(dbgak_pkg::CMD_RESUME_UNTIL_HALT, 1'b0, 1'b0, 0);
    en = 1'b0;
    for (int i = 0; i < 12; i++) begin
      k = dly() - 1;
      if (k < 6) send(cmds[k], en, en, 0);
      else begin
        en = (k == 6);
        send(k == 6 ? dbgak_pkg::CMD_ACK_ON : dbgak_pkg::CMD_ACK_OFF, en, en, 0);
      end
    end
    send(dbgak_pkg::CMD_ACK_ON, 1'b1, 1'b1, 0);
    do_reset();
    check("rerun enable", 2'h0, {devAckEn, hostAckEn});
    send(dbgak_pkg::CMD_WRITE, 1'b0, 1'b0, 0);
    reqValid2 = 1'b1;
    @(posedge clk);
    #1;
    reqValid2 = 1'b0;
    k = 0;
    while (done2 !== 1'b1 && k < 200) begin
      @(posedge clk);
      #1;
      k++;
    end
    check("probe", 2'h0, {acked2, sup2});
    repeat (5) @(posedge clk);
    check("queue empty", 2'h0, {1'b0, expQ.size() != 0});
    test_done();
  end
endmodule
`default_nettype wire
